// ==== stnp_pkg.sv ====
// Shared constants and types for the serial-to-network packer
package stnp_pkg;

   // ==========================================================
   // Buffer geometry
   localparam int DEPTH = 1024;                 // Bytes per port
   localparam int AW = 10;                      // Buffer address width
   localparam int CW = 11;                      // Byte count width, 0..1024
   localparam logic [CW-1:0] CNT_FULL = 11'h400;
   localparam logic [CW-1:0] CNT_ONE = 11'h001;
   localparam logic [CW-1:0] CNT_ZERO = 11'h000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;           // 20 MHz clock
   localparam int MS_NS = 1000000;              // One millisecond in ns
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int MS_PER_MIN = 60000;           // Alive time is in minutes

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] OFF_PACK = 12'h000;
   localparam logic [11:0] OFF_DELIM = 12'h004;
   localparam logic [11:0] OFF_FORCE = 12'h008;
   localparam logic [11:0] OFF_INACT = 12'h00C;
   localparam logic [11:0] OFF_ALIVE = 12'h010;
   localparam logic [11:0] OFF_STATUS = 12'h014;

   // ==========================================================
   // Field positions
   localparam int PLEN_LSB = 0;                 // PACK: packet length, 11 bits
   localparam int D1EN_BIT = 16;                // PACK: first delimiter enable
   localparam int D2EN_BIT = 17;                // PACK: second delimiter enable
   localparam int DPROC_LSB = 18;               // PACK: delimiter process, 2 bits
   localparam int D1_LSB = 0;                   // DELIM: first delimiter byte
   localparam int D2_LSB = 8;                   // DELIM: second delimiter byte
   localparam int ALIVE_LSB = 0;                // ALIVE: minutes, 7 bits
   localparam int REOPEN_BIT = 8;               // ALIVE: listen again after close
   localparam int ST_CNT_LSB = 0;               // STATUS: buffered bytes
   localparam int ST_CONN_LSB = 16;             // STATUS: connection state
   localparam int ST_DRAIN_BIT = 20;            // STATUS: packet being sent

   // ==========================================================
   // Reset values
   localparam logic [CW-1:0] PLEN_RST = 11'h000;
   localparam logic [15:0] TIME_RST = 16'h0000;
   localparam logic [6:0] ALIVE_RST = 7'h07;
   localparam logic [7:0] DELIM_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ==========================================================
   // Modes and states
   typedef enum logic [1:0] {DP_NOTHING, DP_PLUS1, DP_PLUS2, DP_STRIP} stnp_dproc_e;
   typedef enum logic [1:0] {CS_CLOSED, CS_LISTEN, CS_OPEN} stnp_conn_e;

endpackage : stnp_pkg

// ==== stnp_ram.sv ====
// One-kilobyte packing buffer storage for one serial port
`timescale 1ns/1ps
`default_nettype none
module stnp_ram
   import stnp_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Write side
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [7:0] wdata_in,
   // Read side
   input wire logic [AW-1:0] raddr_in,
   output logic [7:0] rdata_out
);
   // Byte array; contents need no reset, the count says what is valid
   logic [7:0] mem [DEPTH];

   // ==========================================================
   // Write port
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   // Asynchronous read; the caller registers the result
   assign rdata_out = mem[raddr_in];
endmodule : stnp_ram
`default_nettype wire

// ==== stnp_timer.sv ====
// Tick-counting gap timer; fires once when the gap exceeds its limit
`timescale 1ns/1ps
`default_nettype none
module stnp_timer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Control
   input wire logic restart_in,
   input wire logic tick_in,
   input wire logic [15:0] limit_in,
   // Result
   output logic expire_out
);
   logic [15:0] cnt;   // Ticks since restart
   logic done;         // Fired already, wait for restart

   // ==========================================================
   // Counter: a zero limit never fires
   always_ff @(posedge clk_in) begin
      if (reset_in || restart_in) begin
         cnt <= 16'h0000;
         done <= 1'b0;
         expire_out <= 1'b0;
      end else begin
         expire_out <= 1'b0;
         if (tick_in && !done && (limit_in != 16'h0000)) begin
            // Fire on the tick after the limit, so the gap exceeds it
            if (cnt == limit_in) begin
               expire_out <= 1'b1;
               done <= 1'b1;
            end else begin
               cnt <= cnt + 16'h0001;
            end
         end
      end
   end
endmodule : stnp_timer
`default_nettype wire

// ==== stnp_packer.sv ====
// Per-port serial packer with connection supervision and APB registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - Nonzero packet length disables delimiter handling
// - Send anyway once one kilobyte accumulates
// - Delimiter process acts only with first delimiter
// - Both delimiters enabled: need both characters
// - Plain mode releases on the delimiter
// - Plus-one mode waits one more byte
// - Plus-two mode waits two more bytes
// - Strip mode removes delimiters before release
// - Store every byte; else full or timeout
// - Force time zero disables the gap timer
// - Release when serial gap exceeds force time
// - One kilobyte buffer per port
// - Keep-alive probes; close without reply in time
// - Alive time zero keeps connection open
// - After close, listen for new connection
// - Close after serial inactivity time
// - Inactivity time zero disables that timeout
// - Release when packet length bytes held
// - First delimiter byte, or the pair when both are enabled, triggers buffer release
module stnp_packer
   import stnp_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS,
   parameter int MS_MIN = MS_PER_MIN
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Serial receive bytes and transmit activity
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   output logic rx_ready_out,
   input wire logic ser_tx_in,
   // Packet stream toward the network
   output logic pkt_valid_out,
   output logic [7:0] pkt_data_out,
   output logic pkt_last_out,
   input wire logic pkt_ready_in,
   // Connection events and state
   input wire logic conn_open_in,
   input wire logic close_req_in,
   input wire logic ka_reply_in,
   output logic conn_active_out,
   output logic listen_out,
   output logic conn_close_out,
   output logic ka_probe_out
);
   // ==========================================================
   // Configuration registers
   logic [CW-1:0] plen;          // Packet length, 0 = none
   logic d1_en;                  // First delimiter enable
   logic d2_en;                  // Second delimiter enable
   stnp_dproc_e dproc;           // Delimiter process
   logic [7:0] delim1;           // First delimiter byte
   logic [7:0] delim2;           // Second delimiter byte
   logic [15:0] force_ms;        // Force transmit gap
   logic [15:0] inact_ms;        // Inactivity time
   logic [6:0] alive_min;        // Alive check time
   logic reopen;                 // Listen again after close

   // Packing state
   logic [CW-1:0] count;         // Bytes held, not yet released
   logic [CW-1:0] pkt_len;       // Length of packet being sent
   logic [CW-1:0] rd;            // Next byte of packet to send
   logic draining;               // Packet leaving the buffer
   logic d1_hit;                 // Last byte was first delimiter
   logic [1:0] trail;            // Trailing bytes still owed
   stnp_conn_e conn;             // Connection state

   // Dividers
   logic [15:0] ms_cnt;
   logic [15:0] min_cnt;
   logic ms_tick;
   logic min_tick;

   // ==========================================================
   // APB decode
   wire apb_acc = psel_in && penable_in && pready_out;
   wire apb_wr = apb_acc && pwrite_in;
   wire hit_pack = (paddr_in == OFF_PACK);
   wire hit_delim = (paddr_in == OFF_DELIM);
   wire hit_force = (paddr_in == OFF_FORCE);
   wire hit_inact = (paddr_in == OFF_INACT);
   wire hit_alive = (paddr_in == OFF_ALIVE);
   wire hit_status = (paddr_in == OFF_STATUS);
   wire hit_any = hit_pack || hit_delim || hit_force || hit_inact || hit_alive || hit_status;

   // Read data; unused bits read as zero
   wire [31:0] rd_pack = WORD_ZERO | (32'(plen) << PLEN_LSB) | (32'(d1_en) << D1EN_BIT)
                         | (32'(d2_en) << D2EN_BIT) | (32'(dproc) << DPROC_LSB);
   wire [31:0] rd_delim = WORD_ZERO | (32'(delim1) << D1_LSB) | (32'(delim2) << D2_LSB);
   wire [31:0] rd_alive = WORD_ZERO | (32'(alive_min) << ALIVE_LSB) | (32'(reopen) << REOPEN_BIT);
   wire [31:0] rd_status = WORD_ZERO | (32'(count) << ST_CNT_LSB) | (32'(conn) << ST_CONN_LSB)
                           | (32'(draining) << ST_DRAIN_BIT);
   wire [31:0] rd_mux = hit_pack ? rd_pack : hit_delim ? rd_delim :
                        hit_force ? 32'(force_ms) : hit_inact ? 32'(inact_ms) :
                        hit_alive ? rd_alive : hit_status ? rd_status : WORD_ZERO;

   // ==========================================================
   // APB handshake: one wait state, answer registered
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= WORD_ZERO;
      end else begin
         pready_out <= psel_in && penable_in && !pready_out;
         pslverr_out <= psel_in && penable_in && !pready_out && !hit_any;
         prdata_out <= (psel_in && penable_in && !pready_out) ? rd_mux : WORD_ZERO;
      end
   end

   // Register writes take effect on the completing edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         plen <= PLEN_RST;
         d1_en <= 1'b0;
         d2_en <= 1'b0;
         dproc <= DP_NOTHING;
         delim1 <= DELIM_RST;
         delim2 <= DELIM_RST;
         force_ms <= TIME_RST;
         inact_ms <= TIME_RST;
         alive_min <= ALIVE_RST;
         reopen <= 1'b1;
      end else if (apb_wr) begin
         if (hit_pack) begin
            plen <= pwdata_in[PLEN_LSB +: CW];
            d1_en <= pwdata_in[D1EN_BIT];
            d2_en <= pwdata_in[D2EN_BIT];
            dproc <= stnp_dproc_e'(pwdata_in[DPROC_LSB +: 2]);
         end
         if (hit_delim) begin
            delim1 <= pwdata_in[D1_LSB +: 8];
            delim2 <= pwdata_in[D2_LSB +: 8];
         end
         if (hit_force) begin
            force_ms <= pwdata_in[15:0];
         end
         if (hit_inact) begin
            inact_ms <= pwdata_in[15:0];
         end
         if (hit_alive) begin
            alive_min <= pwdata_in[ALIVE_LSB +: 7];
            reopen <= pwdata_in[REOPEN_BIT];
         end
      end
   end

   // ==========================================================
   // Millisecond and minute enables
   assign ms_tick = (ms_cnt == 16'(CYC_MS - 1));
   assign min_tick = ms_tick && (min_cnt == 16'(MS_MIN - 1));

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ms_cnt <= 16'h0000;
         min_cnt <= 16'h0000;
      end else begin
         ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
         if (ms_tick) begin
            min_cnt <= min_tick ? 16'h0000 : min_cnt + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Byte intake and release decisions
   wire accept = rx_valid_in && rx_ready_out;
   wire [CW-1:0] eff_len = (plen > CNT_FULL) ? CNT_FULL : plen;
   wire delim_on = (plen == CNT_ZERO) && d1_en;
   wire is_d1 = (rx_data_in == delim1);
   wire is_d2 = (rx_data_in == delim2);
   // With both enabled the pair completes the delimiter; a pending trail swallows it
   wire delim_hit = accept && delim_on && (trail == 2'd0)
                    && (d2_en ? (d1_hit && is_d2) : is_d1);
   wire strip_drop = delim_hit && (dproc == DP_STRIP);
   wire stored = accept && !strip_drop;
   // Strip also takes back the first delimiter already stored
   wire [CW-1:0] cnt_after = stored ? count + CNT_ONE :
                             ((strip_drop && d2_en) ? count - CNT_ONE : count);
   wire len_hit = stored && (plen != CNT_ZERO) && (cnt_after == eff_len);
   wire full_hit = stored && (cnt_after == CNT_FULL);
   wire delim_rel = delim_hit && ((dproc == DP_NOTHING) || (dproc == DP_STRIP));
   wire trail_end = accept && (trail == 2'd1);
   logic force_exp;
   wire release_now = !draining && (cnt_after != CNT_ZERO)
                      && (len_hit || full_hit || delim_rel || trail_end || force_exp);

   // Packet output fetch and end of drain
   logic [7:0] ram_q;
   wire out_free = !pkt_valid_out || pkt_ready_in;
   wire fetch = draining && (rd != pkt_len) && out_free;
   wire drain_done = draining && (rd == pkt_len) && out_free;
   wire next_draining = release_now || (draining && !drain_done);

   // Buffer storage
   stnp_ram u_ram (
      .clk_in(clk_in),
      .we_in(stored),
      .waddr_in(count[AW-1:0]),
      .wdata_in(rx_data_in),
      .raddr_in(rd[AW-1:0]),
      .rdata_out(ram_q)
   );

   // ==========================================================
   // Packing counters; the serial side stalls while a packet drains
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count <= CNT_ZERO;
         pkt_len <= CNT_ZERO;
         draining <= 1'b0;
         d1_hit <= 1'b0;
         trail <= 2'd0;
         rx_ready_out <= 1'b0;
      end else begin
         rx_ready_out <= !next_draining;
         draining <= next_draining;
         if (release_now) begin
            pkt_len <= cnt_after;
            count <= CNT_ZERO;
            d1_hit <= 1'b0;
            trail <= 2'd0;
         end else begin
            count <= cnt_after;
            if (delim_hit && (dproc == DP_PLUS1)) begin
               trail <= 2'd1;
            end else if (delim_hit && (dproc == DP_PLUS2)) begin
               trail <= 2'd2;
            end else if (accept && (trail != 2'd0)) begin
               trail <= trail - 2'd1;
            end
            if (accept && delim_on && d2_en) begin
               d1_hit <= is_d1 && !delim_hit;
            end
         end
      end
   end

   // Packet stream output registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd <= CNT_ZERO;
         pkt_valid_out <= 1'b0;
         pkt_data_out <= 8'h00;
         pkt_last_out <= 1'b0;
      end else begin
         if (release_now) begin
            rd <= CNT_ZERO;
         end else if (fetch) begin
            rd <= rd + CNT_ONE;
         end
         if (fetch) begin
            pkt_valid_out <= 1'b1;
            pkt_data_out <= ram_q;
            pkt_last_out <= ((rd + CNT_ONE) == pkt_len);
         end else if (pkt_ready_in) begin
            pkt_valid_out <= 1'b0;
            pkt_last_out <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Gap and supervision timers
   logic inact_exp;
   logic alive_exp;
   wire is_open = (conn == CS_OPEN);

   // Idle gap only counts while bytes wait
   stnp_timer u_force (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(accept || release_now || (count == CNT_ZERO)),
      .tick_in(ms_tick),
      .limit_in(force_ms),
      .expire_out(force_exp)
   );

   // Serial traffic either way restarts inactivity
   stnp_timer u_inact (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(!is_open || accept || ser_tx_in),
      .tick_in(ms_tick),
      .limit_in(inact_ms),
      .expire_out(inact_exp)
   );

   // A keep-alive reply restarts the alive check
   stnp_timer u_alive (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(!is_open || ka_reply_in),
      .tick_in(min_tick),
      .limit_in(16'(alive_min)),
      .expire_out(alive_exp)
   );

   wire close_now = is_open && (close_req_in || inact_exp || alive_exp);

   // ==========================================================
   // Connection state
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         conn <= CS_LISTEN;
         conn_active_out <= 1'b0;
         listen_out <= 1'b1;
         conn_close_out <= 1'b0;
         ka_probe_out <= 1'b0;
      end else begin
         conn_close_out <= close_now;
         ka_probe_out <= is_open && min_tick && (alive_min != 7'h00);
         unique case (conn)
            CS_CLOSED: begin
               if (reopen) begin
                  conn <= CS_LISTEN;
               end
            end
            CS_LISTEN: begin
               if (conn_open_in) begin
                  conn <= CS_OPEN;
               end
            end
            CS_OPEN: begin
               if (close_now) begin
                  conn <= reopen ? CS_LISTEN : CS_CLOSED;
               end
            end
            default: begin
               conn <= CS_CLOSED;
            end
         endcase
         conn_active_out <= (conn == CS_OPEN) ? !close_now : (conn == CS_LISTEN) && conn_open_in;
         listen_out <= (conn == CS_OPEN) ? (close_now && reopen) :
                       (conn == CS_LISTEN) ? !conn_open_in : reopen;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_delim_plus;
      delim_hit && !release_now;
   endsequence

   len_rel_a: assert property (len_hit && !draining |=> draining && pkt_len == $past(eff_len))
      else $error("packet length reached without release");
   delim_off_a: assert property ((plen != CNT_ZERO) |-> !delim_hit)
      else $error("delimiter acted with nonzero packet length");
   full_rel_a: assert property (stored && count == CNT_FULL - CNT_ONE |=> draining && pkt_len == CNT_FULL)
      else $error("full buffer not released");
   pair_need_a: assert property (delim_hit && d2_en |-> d1_hit && is_d2)
      else $error("second delimiter fired without first");
   plain_rel_a: assert property (delim_hit && dproc == DP_NOTHING |=> draining && pkt_len == $past(count) + CNT_ONE)
      else $error("plain delimiter did not release");
   plus_one_a: assert property (s_delim_plus ##0 dproc == DP_PLUS1 |=> trail == 2'd1)
      else $error("plus one trail not armed");
   plus_two_a: assert property (s_delim_plus ##0 dproc == DP_PLUS2 |=> trail == 2'd2 ##1 !draining)
      else $error("plus two released early");
   strip_len_a: assert property (strip_drop && count > CNT_ONE |=> pkt_len == $past(count) - CNT_ONE + CNT_ONE * !$past(d2_en))
      else $error("strip length wrong");
   force_off_a: assert property (force_ms == TIME_RST |-> !force_exp)
      else $error("force timer fired while disabled");
   release_clr_a: assert property (release_now |=> count == CNT_ZERO && trail == 2'd0 && !d1_hit && !rx_ready_out)
      else $error("release left state behind");
   alive_close_a: assert property (is_open && alive_exp |=> conn != CS_OPEN && conn_close_out)
      else $error("alive expiry did not close");
   alive_off_a: assert property (alive_min == 7'h00 |-> !alive_exp)
      else $error("alive check fired while disabled");
   relisten_a: assert property (close_now && reopen |=> conn == CS_LISTEN && listen_out)
      else $error("no listening after close");
   inact_a: assert property (is_open && inact_exp |=> !conn_active_out)
      else $error("inactivity did not close");
   inact_off_a: assert property (inact_ms == TIME_RST |-> !inact_exp)
      else $error("inactivity fired while disabled");
endmodule : stnp_packer
`default_nettype wire

// ==== stnp_sink.sv ====
// Network-side packet sink model that measures each released packet
`timescale 1ns/1ps
`default_nettype none
module stnp_sink (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Slow mode: ready only every other cycle
   input wire logic stall_in,
   // Packet stream
   input wire logic pkt_valid_in,
   input wire logic pkt_last_in,
   output logic pkt_ready_out,
   // Length of last packet and packet count
   output logic [10:0] len_out,
   output logic [7:0] pkts_out
);
   logic [10:0] cnt; // Bytes so far in this packet
   // ==========
   // Count bytes; stalling exercises the packer's hold of valid and data
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pkt_ready_out <= 1'b0;
         cnt <= 11'h000;
         len_out <= 11'h000;
         pkts_out <= 8'h00;
      end else begin
         pkt_ready_out <= stall_in ? ~pkt_ready_out : 1'b1;
         if (pkt_valid_in && pkt_ready_out) begin
            cnt <= pkt_last_in ? 11'h000 : cnt + 11'h001;
            if (pkt_last_in) begin
               len_out <= cnt + 11'h001;
               pkts_out <= pkts_out + 8'h01;
            end
         end
      end
   end
endmodule : stnp_sink
`default_nettype wire

// ==== stnp_packer_tb.sv ====
// Self-checking testbench for the serial packer
`timescale 1ns/1ps
`default_nettype none
module stnp_packer_tb;
   import stnp_pkg::*;
   // ==========
   // Stimulus and observed signals
   logic clk_in = 0, reset_in = 1, psel = 0, pen = 0, pwr = 0, rxv = 0, stall = 0, copen = 0;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, rd;
   logic [7:0] rxd = 0, pkts;
   logic prdy, perr, er, rxr, pkv, pkl, pkr, act, lis;
   logic stx = 0, kar = 0, cls, kap, cls_seen = 0, ka_seen = 0;
   logic [7:0] pkd, lb = 0;
   logic [10:0] len;
   int mismatches = 0, n_tests = 0;
   initial forever #25 clk_in = ~clk_in;
   stnp_packer #(.CYC_MS(4), .MS_MIN(3)) i_stnp_packer (.clk_in(clk_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(prdy), .pslverr_out(perr), .rx_valid_in(rxv), .rx_data_in(rxd), .rx_ready_out(rxr),
      .ser_tx_in(stx), .pkt_valid_out(pkv), .pkt_data_out(pkd), .pkt_last_out(pkl), .pkt_ready_in(pkr),
      .conn_open_in(copen), .close_req_in(1'b0), .ka_reply_in(kar), .conn_active_out(act),
      .listen_out(lis), .conn_close_out(cls), .ka_probe_out(kap));
   stnp_sink i_stnp_sink (.clk_in(clk_in), .reset_in(reset_in), .stall_in(stall), .pkt_valid_in(pkv),
      .pkt_last_in(pkl), .pkt_ready_out(pkr), .len_out(len), .pkts_out(pkts));
   // Last byte of each packet taken, and sticky flags for the one-cycle pulses
   always @(posedge clk_in) begin
      if (pkv && pkr && pkl) lb <= pkd;
      if (cls) cls_seen <= 1'b1;
      if (kap) ka_seen <= 1'b1;
   end
   // ==========
   // Shared tasks
   task ck(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask : ck
   // One APB transfer; a leading edge keeps back-to-back calls clean
   task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : ap
   // Offer one byte and hold it until taken
   task sb(input logic [7:0] d);
      rxv <= 1'b1;
      rxd <= d;
      do @(posedge clk_in); while (rxr !== 1'b1);
   endtask : sb
   // Expect exactly one new packet of the given length
   task pk(input logic [10:0] e, input logic [7:0] b);
      logic [7:0] p0;
      p0 = pkts;
      rxv <= 1'b0;
      // A full buffer takes over a thousand cycles to drain
      repeat (2000) if (pkts == p0) @(posedge clk_in);
      repeat (4) @(posedge clk_in);
      ck({pkts - p0, len, lb}, {8'h01, e, b});
   endtask : pk
   // Packing mode, up to four bytes low first, expected packet length
   task pkt_case(input logic [31:0] pack, input logic [31:0] b, input int n, input logic [10:0] e,
                 input logic [7:0] lbe);
      ap(1'b1, OFF_PACK, pack);
      for (int i = 0; i < n; i++) sb(b[8*i+:8]);
      pk(e, lbe);
   endtask : pkt_case
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // ==========
   // Watchdog against a hung handshake
   initial begin
      #1_000_000;
      mismatches++;
      summarize;
   end
   // ==========
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      ap(1'b0, OFF_ALIVE, 32'h0000_0000);
      ck(rd, 32'h0000_0107);
      ap(1'b0, 12'h020, 32'h0000_0000);
      ck(er, 1'b1);
      ck(rd, 32'h0000_0000);
      ap(1'b1, OFF_DELIM, 32'h0000_0A0D);
      pkt_case(32'h0001_0000, 32'h000D_0201, 3, 11'h003, 8'h0D);
      pkt_case(32'h0003_0000, 32'h000A_0D01, 3, 11'h003, 8'h0A);
      pkt_case(32'h0005_0000, 32'h0007_0D01, 3, 11'h003, 8'h07);
      pkt_case(32'h0009_0000, 32'h0002_010D, 3, 11'h003, 8'h02);
      stall <= 1'b1;
      pkt_case(32'h000D_0000, 32'h000D_0201, 3, 11'h002, 8'h02);
      pkt_case(32'h0005_0003, 32'h0002_010D, 3, 11'h003, 8'h02);
      stall <= 1'b0;
      ap(1'b1, OFF_PACK, 32'h0001_0000);
      repeat (1024) sb(8'h11);
      pk(11'h400, 8'h11);
      // Bytes arrive back to back, far inside the force time
      ap(1'b1, OFF_FORCE, 32'h0000_0002);
      pkt_case(32'h0000_0000, 32'h0000_0605, 2, 11'h002, 8'h06);
      // Open a link; inactivity off, one reply moves the keep-alive expiry out
      copen <= 1'b1;
      @(posedge clk_in);
      copen <= 1'b0;
      repeat (40) @(posedge clk_in);
      ck(act, 1'b1);
      kar <= 1'b1;
      @(posedge clk_in);
      kar <= 1'b0;
      // Without the reply the link would be closed by now
      repeat (70) @(posedge clk_in);
      ck(act, 1'b1);
      repeat (50) @(posedge clk_in);
      ck({act, lis}, 2'b01);
      ck({cls_seen, ka_seen}, 2'b11);
      ap(1'b1, OFF_INACT, 32'h0000_0003);
      copen <= 1'b1;
      @(posedge clk_in);
      copen <= 1'b0;
      // Outgoing serial traffic keeps the link up, silence closes it
      repeat (5) begin
         stx <= 1'b1;
         @(posedge clk_in);
         stx <= 1'b0;
         repeat (7) @(posedge clk_in);
      end
      ck(act, 1'b1);
      repeat (40) @(posedge clk_in);
      ck({act, lis}, 2'b01);
      summarize;
   end
endmodule : stnp_packer_tb
`default_nettype wire
